// ### design/sct_tunnel.sv
// deserializer end of the spi tunnel: forward regen and reverse capture
// =====================================================
// Functional notes
// R01: host programs mode field to 110 forward or 111 reverse first.
// R02: tunnel configuration only via i2c-reached register 0x43; the back-channel rate bits sit in register 0x23.
// R03: forward mode: remote master drives clock, mosi, active-low select.
// R04: serializer oversamples spi lines on pixel clock into frame bits.
// R05: forward mode: regenerate clock, mosi, select on pixel clock.
// R06: hold regenerated mosi stable while regenerated clock is high.
// R07: delay regenerated clock one pixel clock behind mosi.
// R08: reverse mode: synchronise local select and clock to oscillator.
// R09: reverse mode: capture mosi only on synchronised active clock edge.
// R10: reverse mode: buffer mosi samples, drain in back-channel frames.
// R11: every reverse back-channel frame carries current select state.
// R12: local master keeps select high at least one back-channel frame.
// R13: far end may replay data in bursts; slave tolerates spacing.
// R14: reverse reads: master waits round trip before sampling edge.
// R15: reverse reads: at most one data/clock sample per frame.
// R16: slave shifts read data on falling edge; period exceeds latency.
// R17: tunnel never reaches link-device registers, only external parties.
// R18: back-channel 5/10 Mbps by divider bit, 20 Mbps when high-speed set.
// R19: forward mode: sample local miso, return it over back channel.
module sct_tunnel (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // register access from i2c slave
   input wire sct_pkg::sct_reg_req_s reg_req,
   output logic [7:0] reg_rdata,
   // forward link frame bits and recovered pixel clock
   input wire logic pclk,
   input wire sct_pkg::sct_spi_s fwd_spi,
   // local spi slave (forward mode)
   output sct_pkg::sct_spi_s loc_slave,
   input wire logic loc_miso,
   // local spi master (reverse mode)
   input wire sct_pkg::sct_spi_s loc_master,
   input wire logic read_mode,
   // back channel
   output sct_pkg::sct_bc_frame_s bc_frame,
   output logic bc_miso
);
   import sct_pkg::*;

   // =====================================================
   // pin synchronisers: spi lines, pixel clock and loc_miso pass two flops
   logic [2:0] fs1_q, fs2_q, ms1_q, ms2_q;
   logic [1:0] ps1_q, ps2_q;
   logic [2:0] fs1_d, fs2_d, ms1_d, ms2_d;
   logic [1:0] ps1_d, ps2_d;
   always_comb begin
      fs1_d = {fwd_spi.sclk, fwd_spi.mosi, fwd_spi.ss_n};
      fs2_d = fs1_q;
      ms1_d = {loc_master.sclk, loc_master.mosi, loc_master.ss_n};
      ms2_d = ms1_q; // R08
      ps1_d = {pclk, loc_miso};
      ps2_d = ps1_q;
   end
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         fs1_q <= 3'h7;
         fs2_q <= 3'h7;
         ms1_q <= 3'h1;
         ms2_q <= 3'h1;
         ps1_q <= 2'h0;
         ps2_q <= 2'h0;
      end else begin
         fs1_q <= fs1_d;
         fs2_q <= fs2_d;
         ms1_q <= ms1_d;
         ms2_q <= ms2_d;
         ps1_q <= ps1_d;
         ps2_q <= ps2_d;
      end
   end

   // =====================================================
   // registers: only the i2c path writes them, spi never does
   logic [7:0] hscc_q, hscc_d, bccfg_q, bccfg_d, rdata_q, rdata_d;
   always_comb begin
      hscc_d = hscc_q;
      bccfg_d = bccfg_q;
      rdata_d = 8'h00; // unmapped reads as zero
      if (reg_req.wr && reg_req.addr == SCT_HSCC_ADDR)
         hscc_d = reg_req.wdata; // R02 R01
      if (reg_req.wr && reg_req.addr == SCT_BCCFG_ADDR)
         bccfg_d = reg_req.wdata;
      if (reg_req.addr == SCT_HSCC_ADDR)
         rdata_d = hscc_q;
      else if (reg_req.addr == SCT_BCCFG_ADDR)
         rdata_d = bccfg_q;
   end
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         hscc_q <= SCT_HSCC_RESET;
         bccfg_q <= SCT_BCCFG_RESET;
         rdata_q <= 8'h00;
      end else begin
         hscc_q <= hscc_d;
         bccfg_q <= bccfg_d;
         rdata_q <= rdata_d;
      end
   end
   assign reg_rdata = rdata_q;

   logic fwd_en, rev_en;
   assign fwd_en = hscc_q[SCT_MODE_MSB:SCT_MODE_LSB] == SCT_MODE_SPI_FWD;
   assign rev_en = hscc_q[SCT_MODE_MSB:SCT_MODE_LSB] == SCT_MODE_SPI_REV;

   // =====================================================
   // forward regeneration on pixel-clock rising edges
   logic pclk_rise;
   logic pclk_prev_q, pclk_prev_d;
   logic clk_dly_q, clk_dly_d, mosi_q, mosi_d, ss_q, ss_d, sclk_q, sclk_d;
   logic miso_q, miso_d;
   assign pclk_rise = ps2_q[1] & ~pclk_prev_q;
   always_comb begin
      pclk_prev_d = ps2_q[1];
      clk_dly_d = clk_dly_q;
      mosi_d = mosi_q;
      ss_d = ss_q;
      sclk_d = sclk_q;
      miso_d = miso_q;
      if (!fwd_en) begin
         sclk_d = 1'b0;
         ss_d = 1'b1;
      end else if (pclk_rise) begin // R05
         clk_dly_d = fs2_q[2];
         sclk_d = clk_dly_q; // R07
         ss_d = fs2_q[0];
         if (!clk_dly_q && !fs2_q[2])
            mosi_d = fs2_q[1]; // R06
         if (sclk_q && !clk_dly_q)
            miso_d = ps2_q[0]; // R19 R16
      end
   end
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pclk_prev_q <= 1'b0;
         clk_dly_q <= 1'b0;
         mosi_q <= 1'b0;
         ss_q <= 1'b1;
         sclk_q <= 1'b0;
         miso_q <= 1'b0;
      end else begin
         pclk_prev_q <= pclk_prev_d;
         clk_dly_q <= clk_dly_d;
         mosi_q <= mosi_d;
         ss_q <= ss_d;
         sclk_q <= sclk_d;
         miso_q <= miso_d;
      end
   end
   assign loc_slave = '{sclk: sclk_q, mosi: mosi_q, ss_n: ss_q};
   assign bc_miso = miso_q; // R17

   // =====================================================
   // back-channel bit timing: 20 Mbps overrides divider bit
   function automatic logic [7:0] bc_div(input logic [7:0] cfg);
      if (cfg[SCT_BC_HS_BIT])
         return SCT_DIV_HS;
      return cfg[SCT_BC_DIV_BIT] ? SCT_DIV_MID : SCT_DIV_SLOW;
   endfunction
   logic [7:0] div_cnt_q, div_cnt_d;
   logic [7:0] bit_cnt_q, bit_cnt_d;
   logic frame_end;
   always_comb begin
      div_cnt_d = div_cnt_q + 8'h01;
      bit_cnt_d = bit_cnt_q;
      frame_end = 1'b0;
      if (div_cnt_q + 8'h01 >= bc_div(bccfg_q)) begin // R18
         div_cnt_d = 8'h00;
         bit_cnt_d = bit_cnt_q + 8'h01;
         if (bit_cnt_q == 8'(SCT_FRAME_BITS - 1)) begin
            bit_cnt_d = 8'h00;
            frame_end = 1'b1;
         end
      end
   end
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         div_cnt_q <= 8'h00;
         bit_cnt_q <= 8'h00;
      end else begin
         div_cnt_q <= div_cnt_d;
         bit_cnt_q <= bit_cnt_d;
      end
   end

   // =====================================================
   // reverse capture buffer; a full buffer drops new samples, so the
   // master must pace itself against the frame rate
   logic [SCT_BUF_DEPTH-1:0] buf_q, buf_d;
   logic [4:0] fill_q, fill_d;
   logic sclk_prev_q, sclk_prev_d;
   logic [3:0] take;
   sct_bc_frame_s frame_q, frame_d;
   always_comb begin
      buf_d = buf_q;
      fill_d = fill_q;
      sclk_prev_d = ms2_q[2];
      frame_d = frame_q;
      frame_d.valid = 1'b0;
      take = 4'h0;
      if (frame_end && rev_en) begin // R10
         take = read_mode ? 4'(SCT_FWD_SAMPLES)
                          : 4'(SCT_REV_WR_SAMPLES); // R15
         if ({1'b0, take} > fill_q)
            take = fill_q[3:0];
         frame_d.valid = 1'b1;
         frame_d.ss_n = ms2_q[0]; // R11 R12
         frame_d.count = take;
         frame_d.bits = buf_q[7:0];
         buf_d = buf_q >> take;
         fill_d = fill_q - {1'b0, take};
      end
      if (!rev_en) begin
         fill_d = 5'h00;
      end else if (ms2_q[2] && !sclk_prev_q && !ms2_q[0] &&
                   fill_d < 5'(SCT_BUF_DEPTH)) begin
         buf_d[fill_d[3:0]] = ms2_q[1]; // R09
         fill_d = fill_d + 5'h01;
      end
   end
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         buf_q <= 16'h0000;
         fill_q <= 5'h00;
         sclk_prev_q <= 1'b0;
         frame_q <= '{valid: 1'b0, ss_n: 1'b1, count: 4'h0, bits: 8'h00};
      end else begin
         buf_q <= buf_d;
         fill_q <= fill_d;
         sclk_prev_q <= sclk_prev_d;
         frame_q <= frame_d;
      end
   end
   assign bc_frame = frame_q;
endmodule

// ### design/sct_pkg.sv
// package for the spi control channel tunnel (deserializer side)
package sct_pkg;
   // =====================================================
   // register map
   localparam logic [7:0] SCT_HSCC_ADDR = 8'h43;
   localparam logic [7:0] SCT_HSCC_RESET = 8'h00;
   localparam logic [7:0] SCT_BCCFG_ADDR = 8'h23;
   localparam logic [7:0] SCT_BCCFG_RESET = 8'h00;
   localparam int SCT_MODE_LSB = 0;
   localparam int SCT_MODE_MSB = 2;
   localparam int SCT_BC_DIV_BIT = 6;
   localparam int SCT_BC_HS_BIT = 4;
   localparam logic [2:0] SCT_MODE_SPI_FWD = 3'h6;
   localparam logic [2:0] SCT_MODE_SPI_REV = 3'h7;

   // =====================================================
   // back-channel timing: oscillator at 20 MHz, one bit per divide
   localparam int SCT_CLK_HZ = 20_000_000;
   localparam int SCT_FRAME_BITS = 30;  // 6 us at 5 Mbps
   localparam logic [7:0] SCT_DIV_SLOW = 8'h04;  // 5 Mbps
   localparam logic [7:0] SCT_DIV_MID = 8'h02;   // 10 Mbps
   localparam logic [7:0] SCT_DIV_HS = 8'h01;    // 20 Mbps
   localparam int SCT_BUF_DEPTH = 16;
   localparam int SCT_FWD_SAMPLES = 1;
   localparam int SCT_REV_WR_SAMPLES = 8;

   // =====================================================
   // carriers
   typedef struct packed {
      logic sclk;
      logic mosi;
      logic ss_n;
   } sct_spi_s;

   typedef struct packed {
      logic valid;     // one-cycle frame strobe
      logic ss_n;      // slave-select state
      logic [3:0] count;
      logic [7:0] bits;
   } sct_bc_frame_s;

   typedef struct packed {
      logic wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } sct_reg_req_s;
endpackage

// ### verif/sct_tunnel_properties.sv
// port checker for the spi tunnel, bound onto the design
module sct_tunnel_properties import sct_pkg::*; (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // register side
   input wire sct_pkg::sct_reg_req_s reg_req,
   input wire logic [7:0] reg_rdata,
   // spi and back channel
   input wire sct_pkg::sct_spi_s loc_slave,
   input wire sct_pkg::sct_spi_s loc_master,
   input wire logic read_mode,
   input wire sct_pkg::sct_bc_frame_s bc_frame
);
   logic [2:0] mode_q;
   logic [2:0] mode_d;
   // =====================================================
   // shadow of the mode field, so checks know the mode
   always_comb begin
      mode_d = mode_q;
      if (reg_req.wr && reg_req.addr == SCT_HSCC_ADDR) begin
         mode_d = reg_req.wdata[2:0];
      end
   end
   always_ff @(posedge ref_clk) begin
      mode_q <= rst ? 3'h0 : mode_d;
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   // =====================================================
   // assertions
   a_unmapped_zero: assert property (
      reg_req.addr != SCT_HSCC_ADDR && reg_req.addr != SCT_BCCFG_ADDR
      |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
   a_mode_readback: assert property (
      reg_req.wr && reg_req.addr == SCT_HSCC_ADDR ##1
      !reg_req.wr && reg_req.addr == SCT_HSCC_ADDR
      |=> reg_rdata == $past(reg_req.wdata, 2)) else $error("bad readback");
   a_mosi_frozen: assert property (
      loc_slave.sclk && $past(loc_slave.sclk) |-> $stable(loc_slave.mosi))
      else $error("mosi moved while clock high");
   a_sclk_lags: assert property (
      $rose(loc_slave.sclk) |-> $stable(loc_slave.mosi))
      else $error("clock rose with mosi");
   a_idle_off: assert property (
      (mode_q != SCT_MODE_SPI_FWD)[*4] |-> !loc_slave.sclk && loc_slave.ss_n)
      else $error("slave lines active outside forward");
   a_no_frames: assert property (
      (mode_q != SCT_MODE_SPI_REV)[*4] |-> !bc_frame.valid)
      else $error("frame outside reverse");
   a_valid_pulse: assert property (
      bc_frame.valid |=> !bc_frame.valid) else $error("frame strobe long");
   a_frame_select: assert property (
      $stable(loc_master.ss_n)[*6] ##0 bc_frame.valid
      |-> bc_frame.ss_n == loc_master.ss_n) else $error("frame select wrong");
   a_read_single: assert property (
      bc_frame.valid && read_mode |-> bc_frame.count <= 4'h1)
      else $error("read frame holds several samples");
   a_count_limit: assert property (
      bc_frame.valid |-> bc_frame.count <= 4'h8) else $error("count too big");
   c_frame_data: cover property (bc_frame.valid && bc_frame.count != 4'h0);
   c_fwd_clock: cover property ($rose(loc_slave.sclk));
   c_read_frame: cover property (bc_frame.valid && read_mode);
endmodule
bind sct_tunnel sct_tunnel_properties u_props (.ref_clk(ref_clk), .rst(rst),
   .reg_req(reg_req), .reg_rdata(reg_rdata), .loc_slave(loc_slave),
   .loc_master(loc_master), .read_mode(read_mode), .bc_frame(bc_frame));

// ### verif/sct_partner.sv
// far side: remote master frames, local master and echoing local slave
module sct_partner import sct_pkg::*; (
   // toward the tunnel
   output logic pclk,
   output sct_pkg::sct_spi_s fwd_spi,
   output sct_pkg::sct_spi_s loc_master,
   output logic loc_miso,
   // from the tunnel
   input wire sct_pkg::sct_spi_s loc_slave
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      pclk = 1'b0;
      fwd_spi = 3'b001;
      loc_master = 3'b001;
      loc_miso = 1'b0;
   end
   // pixel clock free running at eight ref_clk periods, edges on ref_clk falling edges
   always #200 pclk = ~pclk;
   // slave shifts toward the master on the falling clock
   // a deselected slave keeps its line, so the unknown-to-zero clock step
   // at reset cannot load an unknown echo
   always @(negedge loc_slave.sclk) begin
      if (!loc_slave.ss_n)
         loc_miso <= loc_slave.mosi;
   end
   // one remote bit, frame bits change off the pixel clock
   task automatic fwd_bit(input logic b);
      repeat (3) @(negedge pclk);
      fwd_spi = {1'b0, b, 1'b0};
      repeat (3) @(negedge pclk);
      fwd_spi.sclk = 1'b1;
      repeat (3) @(negedge pclk);
      fwd_spi.sclk = 1'b0;
   endtask
   // one local master bit, slow so no sample is lost
   task automatic rev_bit(input logic b);
      loc_master = {1'b0, b, 1'b0};
      #500 loc_master.sclk = 1'b1;
      #500 loc_master.sclk = 1'b0;
   endtask
   // release both selects; released data shows the inverse
   task automatic idle();
      fwd_spi = {1'b0, ~fwd_spi.mosi, 1'b1};
      loc_master = {1'b0, ~loc_master.mosi, 1'b1};
   endtask
endmodule

// ### verif/sct_tunnel_bench.sv
// self-checking bench for the spi tunnel
module sct_tunnel_bench import sct_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic read_mode = 1'b0;
   sct_reg_req_s reg_req = '0;
   logic [7:0] reg_rdata;
   logic pclk;
   logic loc_miso;
   logic bc_miso;
   sct_spi_s fwd_spi;
   sct_spi_s loc_slave;
   sct_spi_s loc_master;
   sct_bc_frame_s bc_frame;
   int n_fail = 0;
   int cmp_count = 0;
   int gap;
   logic [7:0] cfg[3] = '{8'h00, 8'h40, 8'h50};
   logic [7:0] dv[3] = '{SCT_DIV_SLOW, SCT_DIV_MID, SCT_DIV_HS};
   always #25 ref_clk = ~ref_clk;
   sct_tunnel dut (.ref_clk, .rst, .reg_req, .reg_rdata, .pclk, .fwd_spi,
      .loc_slave, .loc_miso, .loc_master, .read_mode, .bc_frame, .bc_miso);
   sct_partner u_far (.pclk, .fwd_spi, .loc_master, .loc_miso, .loc_slave);
   task automatic check(input logic [11:0] seen, input logic [11:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic test_done();
      if (n_fail == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge ref_clk);
      reg_req = {1'b1, a, d};
      @(negedge ref_clk);
      reg_req.wr = 1'b0;
   endtask
   task automatic reg_chk(input logic [7:0] a, input logic [7:0] e);
      @(negedge ref_clk);
      reg_req.addr = a;
      @(negedge ref_clk);
      check(12'(reg_rdata), 12'(e));
   endtask
   // wait for one frame strobe, counting cycles
   task automatic next_frame();
      gap = 0;
      do begin
         @(negedge ref_clk);
         gap++;
      end while (bc_frame.valid !== 1'b1 && gap < 400);
   endtask
   // =====================================================
   // main sequence
   initial begin
      repeat (8) @(negedge ref_clk);
      rst = 1'b0;
      reg_chk(SCT_HSCC_ADDR, SCT_HSCC_RESET);
      reg_chk(8'h10, 8'h00);
      reg_wr(SCT_HSCC_ADDR, {5'h00, SCT_MODE_SPI_FWD});
      reg_chk(SCT_HSCC_ADDR, {5'h00, SCT_MODE_SPI_FWD});
      for (int i = 0; i < 3; i++) begin
         u_far.fwd_bit(~i[0]);
         @(negedge ref_clk);
         check(12'(loc_slave), 12'({1'b1, ~i[0], 1'b0}));
         // miso is taken as the clock falls: it returns the echo of the
         // previous bit, and the idle level for the first clock
         repeat (16) @(negedge ref_clk);
         check(12'(bc_miso), 12'(i[0]));
      end
      repeat (40) @(negedge ref_clk);
      check(12'(bc_miso), 12'h000);
      u_far.idle();
      reg_wr(SCT_HSCC_ADDR, {5'h00, SCT_MODE_SPI_REV});
      // each rate: period, then one sample and the select state
      for (int r = 0; r < 3; r++) begin
         reg_wr(SCT_BCCFG_ADDR, cfg[r]);
         repeat (3) next_frame();
         check(12'(gap), 12'(SCT_FRAME_BITS * dv[r]));
         fork
            u_far.rev_bit(r[0]);
            do next_frame(); while (bc_frame.count === 4'h0);
         join
         check(12'({bc_frame.ss_n, bc_frame.count, bc_frame.bits[0]}),
            12'({1'b0, 4'h1, r[0]}));
         u_far.idle();
         repeat (2) next_frame();
         check(12'(bc_frame.ss_n), 12'h001);
      end
      // reads at the slow rate, so several samples queue in one frame time
      read_mode = 1'b1;
      reg_wr(SCT_BCCFG_ADDR, cfg[0]);
      repeat (3) u_far.rev_bit(1'b1);
      repeat (3) begin
         do next_frame(); while (bc_frame.count === 4'h0);
         check(12'({bc_frame.count, bc_frame.bits[0]}), 12'h003);
      end
      test_done();
   end
   // watchdog well beyond the expected run
   initial begin
      #400_000;
      n_fail++;
      test_done();
   end
endmodule
